// [shared/pvt_pkg.sv]
// Purpose: shared constants for the pixel input and trigger front end
// Assumes: AXI4-Lite register words, byte addresses below
// Notes: one clock at 100 MHz drives every count here
package pvt_pkg;
	// Register byte addresses
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_PATTERN = 8'h08;
	localparam logic [7:0] REG_EXPOSURE = 8'h0c;
	localparam logic [7:0] REG_GPIO = 8'h10;
	localparam logic [7:0] REG_FRAMES = 8'h14;
	// Control field positions
	localparam int CTRL_PAT = 0;
	localparam int CTRL_LVDS = 1;
	localparam int CTRL_TRIG = 2;
	localparam int CTRL_WIDTH = 4;
	localparam int SWAP_R = 6;
	localparam int SWAP_G = 8;
	localparam int SWAP_B = 10;
	// Status field positions
	localparam int ST_LOST = 0;
	localparam int ST_OVF = 1;
	localparam int ST_STRAP = 2;
	localparam int ST_INIT = 3;
	localparam int ST_PAUSE = 4;
	// Values after reset
	localparam logic [11:0] CTRL_RESET = 12'h900;
	localparam logic [7:0] PATTERN_RESET = 8'h02;
	localparam logic [15:0] EXPOSURE_RESET = 16'h03e8;
	// Serial control slave address pairs, first of each pair
	localparam logic [6:0] ADDR_LOW_SET = 7'h34;
	localparam logic [6:0] ADDR_HIGH_SET = 7'h3a;
	// Timing
	localparam int CLK_MHZ = 100;
	localparam int US_CYCLES = CLK_MHZ;
	localparam int INIT_US = 10;
	localparam int INIT_CYCLES = INIT_US * CLK_MHZ;
	localparam int SYNC_TIMEOUT_MS = 100;
	localparam int SYNC_TIMEOUT_CYCLES = SYNC_TIMEOUT_MS * 1000 * CLK_MHZ;
	localparam int LVDS_BEATS = 8;
	// Bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Exposure states
	typedef enum logic {PVT_IDLE, PVT_EXPOSE} pvt_expo_e;
endpackage

// [design/pvt_fifo.sv]
// Purpose: small flip-flop FIFO between pixel capture and the output stream
// Assumes: DEPTH is a power of two, at least two
// Notes: honest full and empty; drain side may stall
`timescale 1ns/1ns
module pvt_fifo #(
	parameter int WIDTH = 30,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Fill side
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	// Drain side
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wrPtr;
		logic [AW-1:0] rdPtr;
		logic [AW:0] count;
	} pvt_fifo_s;

	pvt_fifo_s st;
	pvt_fifo_s next_st;
	logic push;
	logic pop;

	// Refuse depths the pointer wrap cannot serve
	if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_check
		$error("pvt_fifo needs a power-of-two depth of at least two");
	end

	// Flags and head word
	assign inReady = (st.count != (AW + 1)'(DEPTH));
	assign outValid = (st.count != '0);
	assign outData = st.mem[st.rdPtr];
	assign push = inValid && inReady;
	assign pop = outValid && outReady;

	// Next state
	always_comb begin
		next_st = st;
		if (push) begin
			next_st.mem[st.wrPtr] = inData;
			next_st.wrPtr = st.wrPtr + 1'b1;
		end
		if (pop) begin
			next_st.rdPtr = st.rdPtr + 1'b1;
		end
		next_st.count = st.count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
	end

	// State register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
endmodule

// [design/pvt_input_trigger.sv]
// Purpose: pixel input, pattern trigger and address strap front end
// Assumes: clk is the one timing reference; pixel and LVDS clocks below clk/4
// Notes: pixel pins pass two flops, edges found on the synced clock copy
//
// The placing of the registers and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ns
module pvt_input_trigger
	import pvt_pkg::*;
#(
	parameter int SYNC_TIMEOUT = SYNC_TIMEOUT_CYCLES,
	parameter int FIFO_DEPTH = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// AXI4-Lite slave
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Parallel pixel port
	input wire logic [29:0] rgbPixelBus,
	input wire logic sourcePixelClock,
	input wire logic frameSyncIn,
	input wire logic lineSyncIn,
	input wire logic pixelValidIn,
	// Serial differential port, after the receivers
	input wire logic lvdsClockIn,
	input wire logic lvdsLaneA,
	input wire logic lvdsLaneB,
	input wire logic lvdsLaneC,
	input wire logic lvdsLaneE,
	// Triggers
	input wire logic advanceTriggerIn,
	input wire logic pauseTriggerIn,
	output logic exposureStrobeOut,
	output logic firstPatternStrobeOut,
	// Address strap pin, later general purpose
	input wire logic addrSelIn,
	output logic addrSelOut,
	output logic addrSelOe,
	output logic [6:0] hostCtrlAddress,
	// Pixel stream to the display path
	output logic [29:0] pixOut,
	output logic pixOutValid,
	input wire logic pixOutReady,
	output logic frameStartOut,
	output logic frameRepeatOut,
	output logic [7:0] patternIndexOut
);
	if (SYNC_TIMEOUT < 2 || SYNC_TIMEOUT >= (1 << 24)) begin : g_check
		$error("pvt_input_trigger sync timeout out of range");
	end

	typedef struct packed {
		logic awready; logic wready; logic [1:0] bresp; logic bvalid;
		logic arready; logic [31:0] rdata; logic [1:0] rresp; logic rvalid;
		logic [11:0] ctrl; logic [7:0] patCount; logic [15:0] expoUs;
		logic gpioOut; logic gpioOe; logic addrSelOe;
		logic [2:0] pclk; logic [2:0] vs; logic [2:0] hs; logic [1:0] de;
		logic [29:0] data1; logic [29:0] data2;
		logic [2:0] lclk; logic [3:0] lanes1; logic [3:0] lanes2;
		logic [31:0] lvdsShift; logic [2:0] lvdsBeat;
		logic [2:0] trigA; logic [2:0] trigB; logic [1:0] strap;
		logic pushValid; logic [29:0] pushData; logic overflow;
		logic syncLost; logic dataSeen; logic [23:0] timeout;
		logic [15:0] frameCount; logic [15:0] repeatCount;
		logic frameStart; logic frameRepeat;
		logic [9:0] initCnt; logic initDone; logic strapHigh; logic [6:0] addr;
		logic [7:0] patIdx; logic paused; pvt_expo_e expo;
		logic [6:0] usCnt; logic [15:0] expoCnt;
		logic expoStrobe; logic firstStrobe;
		logic [29:0] pixOut; logic pixOutValid;
	} pvt_state_s;

	pvt_state_s st;
	pvt_state_s next_st;
	logic fifoInReady;
	logic fifoOutValid;
	logic fifoOutReady;
	logic [29:0] fifoOutData;
	logic vsRise;
	logic pclkRise;
	logic step;

	// Pick one board lane for a colour
	function automatic logic [9:0] pvt_pick(input logic [29:0] raw, input logic [1:0] sel);
		case (sel)
			2'h0: pvt_pick = raw[29:20];
			2'h1: pvt_pick = raw[19:10];
			default: pvt_pick = raw[9:0];
		endcase
	endfunction

	// Swap lanes, then keep the top bits in pattern mode
	function automatic logic [29:0] pvt_format(input logic [29:0] raw, input logic [11:0] c);
		logic [29:0] rgb;
		rgb = {pvt_pick(raw, c[SWAP_R+:2]), pvt_pick(raw, c[SWAP_G+:2]),
			pvt_pick(raw, c[SWAP_B+:2])};
		if (c[CTRL_PAT]) begin
			pvt_format = {6'h00, rgb[29:22], rgb[19:12], rgb[9:2]};
		end else begin
			pvt_format = rgb;
		end
	endfunction

	// Byte-lane merge of a write
	function automatic logic [31:0] pvt_merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] s);
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				old[8*i+:8] = d[8*i+:8];
			end
		end
		pvt_merge = old;
	endfunction

	// Ring step modulo the pattern count
	function automatic logic [7:0] pvt_wrap(input logic [7:0] idx, input logic [7:0] inc,
		input logic [7:0] cnt);
		logic [8:0] sum;
		logic [8:0] lim;
		lim = (cnt == 8'h00) ? 9'h001 : {1'b0, cnt};
		sum = {1'b0, idx} + {1'b0, inc};
		// Two folds cover a step of two; a shrunk count restarts at zero
		for (int i = 0; i < 2; i++) begin
			if (sum >= lim) begin
				sum = sum - lim;
			end
		end
		if (sum >= lim) begin
			sum = 9'h000;
		end
		pvt_wrap = sum[7:0];
	endfunction

	// Edges on the synced copies only
	assign pclkRise = st.pclk[1] && !st.pclk[2];
	assign vsRise = st.vs[1] && !st.vs[2];
	assign fifoOutReady = !st.pixOutValid || pixOutReady;

	pvt_fifo #(.WIDTH(30), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk(clk),
		.rst(rst),
		.inValid(st.pushValid),
		.inReady(fifoInReady),
		.inData(st.pushData),
		.outValid(fifoOutValid),
		.outReady(fifoOutReady),
		.outData(fifoOutData)
	);

	// Next state of the whole block
	always_comb begin
		logic [31:0] merged;
		logic [31:0] lvdsNext;
		logic [9:0] keep;
		logic [1:0] trigStep;
		merged = 32'h0;
		lvdsNext = 32'h0;
		keep = 10'h3ff;
		trigStep = 2'h0;
		step = 1'b0;
		next_st = st;
		// Pin synchronisers
		next_st.pclk = {st.pclk[1:0], sourcePixelClock};
		next_st.vs = {st.vs[1:0], frameSyncIn};
		next_st.hs = {st.hs[1:0], lineSyncIn};
		next_st.de = {st.de[0], pixelValidIn};
		next_st.data1 = rgbPixelBus;
		next_st.data2 = st.data1;
		next_st.lclk = {st.lclk[1:0], lvdsClockIn};
		next_st.lanes1 = {lvdsLaneA, lvdsLaneB, lvdsLaneC, lvdsLaneE};
		next_st.lanes2 = st.lanes1;
		next_st.trigA = {st.trigA[1:0], advanceTriggerIn};
		next_st.trigB = {st.trigB[1:0], pauseTriggerIn};
		next_st.strap = {st.strap[0], addrSelIn};
		// Write channel, address and data taken together
		next_st.awready = 1'b0;
		next_st.wready = 1'b0;
		if (awvalid && wvalid && !st.awready && !st.bvalid) begin
			next_st.awready = 1'b1;
			next_st.wready = 1'b1;
		end
		if (st.bvalid && bready) begin
			next_st.bvalid = 1'b0;
		end
		if (st.awready && awvalid && wvalid) begin
			next_st.bvalid = 1'b1;
			next_st.bresp = RESP_OKAY;
			if (awaddr == REG_CTRL) begin
				merged = pvt_merge({20'h0, st.ctrl}, wdata, wstrb);
				next_st.ctrl = merged[11:0];
			end else if (awaddr == REG_STATUS) begin
				if (wstrb[0] && wdata[ST_OVF]) begin
					next_st.overflow = 1'b0;
				end
			end else if (awaddr == REG_PATTERN) begin
				merged = pvt_merge({24'h0, st.patCount}, wdata, wstrb);
				next_st.patCount = merged[7:0];
			end else if (awaddr == REG_EXPOSURE) begin
				merged = pvt_merge({16'h0, st.expoUs}, wdata, wstrb);
				next_st.expoUs = merged[15:0];
			end else if (awaddr == REG_GPIO) begin
				merged = pvt_merge({30'h0, st.gpioOe, st.gpioOut}, wdata, wstrb);
				next_st.gpioOut = merged[0];
				next_st.gpioOe = merged[1];
			end else if (awaddr != REG_FRAMES) begin
				next_st.bresp = RESP_SLVERR;
			end
		end
		// Read channel, answer one cycle after the address is taken
		next_st.arready = 1'b0;
		if (arvalid && !st.arready && !st.rvalid) begin
			next_st.arready = 1'b1;
		end
		if (st.rvalid && rready) begin
			next_st.rvalid = 1'b0;
		end
		if (st.arready && arvalid) begin
			next_st.rvalid = 1'b1;
			next_st.rresp = RESP_OKAY;
			next_st.rdata = 32'h0;
			if (araddr == REG_CTRL) begin
				next_st.rdata = {20'h0, st.ctrl};
			end else if (araddr == REG_STATUS) begin
				next_st.rdata = {9'h0, st.addr, st.patIdx, 3'h0, st.paused, st.initDone,
					st.strapHigh, st.overflow, st.syncLost};
			end else if (araddr == REG_PATTERN) begin
				next_st.rdata = {24'h0, st.patCount};
			end else if (araddr == REG_EXPOSURE) begin
				next_st.rdata = {16'h0, st.expoUs};
			end else if (araddr == REG_GPIO) begin
				next_st.rdata = {29'h0, st.strap[1], st.gpioOe, st.gpioOut};
			end else if (araddr == REG_FRAMES) begin
				next_st.rdata = {st.repeatCount, st.frameCount};
			end else begin
				next_st.rresp = RESP_SLVERR;
			end
		end
		// Sync watchdog: no periodic frame sync, no pixels taken
		if (vsRise) begin
			next_st.timeout = 24'h0;
			next_st.syncLost = 1'b0;
		end else if (st.timeout == 24'(SYNC_TIMEOUT - 1)) begin
			next_st.syncLost = 1'b1;
		end else begin
			next_st.timeout = st.timeout + 24'h1;
		end
		// Frame boundary: adopt new frame or repeat the last one
		next_st.frameStart = vsRise;
		if (vsRise) begin
			next_st.frameRepeat = !st.dataSeen;
			next_st.dataSeen = 1'b0;
			if (st.dataSeen) begin
				next_st.frameCount = st.frameCount + 16'h1;
			end else begin
				next_st.repeatCount = st.repeatCount + 16'h1;
			end
		end
		// Capture from the selected port into the FIFO
		next_st.pushValid = 1'b0;
		if (st.ctrl[CTRL_LVDS]) begin
			if (st.hs[1] && !st.hs[2]) begin
				next_st.lvdsBeat = 3'h0;
			end else if (st.lclk[1] && !st.lclk[2]) begin
				lvdsNext = {st.lvdsShift[27:0], st.lanes2};
				next_st.lvdsShift = lvdsNext;
				next_st.lvdsBeat = st.lvdsBeat + 3'h1;
				if (st.lvdsBeat == 3'(LVDS_BEATS - 1) && !st.syncLost) begin
					if (st.ctrl[CTRL_WIDTH+:2] == 2'h0) begin
						keep = 10'h3fc;
					end else if (st.ctrl[CTRL_WIDTH+:2] == 2'h1) begin
						keep = 10'h3fe;
					end
					next_st.pushValid = 1'b1;
					next_st.pushData = pvt_format(lvdsNext[29:0] & {3{keep}}, st.ctrl);
					next_st.dataSeen = 1'b1;
				end
			end
		end else if (pclkRise && st.de[1] && !st.syncLost) begin
			next_st.pushValid = 1'b1;
			next_st.pushData = pvt_format(st.data2, st.ctrl);
			next_st.dataSeen = 1'b1;
		end
		// A capture the FIFO cannot take is flagged; set wins over clear
		if (st.pushValid && !fifoInReady) begin
			next_st.overflow = 1'b1;
		end
		// Output stream register
		if (fifoOutReady) begin
			next_st.pixOutValid = fifoOutValid;
			next_st.pixOut = fifoOutData;
		end
		// Strap caught once after reset release, then pin is general purpose
		if (!st.initDone) begin
			next_st.initCnt = st.initCnt + 10'h1;
			if (st.initCnt == 10'(INIT_CYCLES - 1)) begin
				next_st.initDone = 1'b1;
				next_st.strapHigh = st.strap[1];
				next_st.addr = st.strap[1] ? ADDR_HIGH_SET : ADDR_LOW_SET;
			end
		end
		next_st.addrSelOe = st.initDone && st.gpioOe;
		// Trigger inputs in pattern mode
		if (st.ctrl[CTRL_PAT]) begin
			if (!st.ctrl[CTRL_TRIG]) begin
				next_st.paused = st.trigB[1];
				if (st.trigA[1] && !st.trigA[2] && !st.paused) begin
					trigStep = 2'h1;
				end
			end else begin
				next_st.paused = 1'b0;
				if (st.trigA[1] && !st.trigA[2]) begin
					step = 1'b1;
					next_st.patIdx = (st.patIdx == 8'h00) ? 8'h01 : 8'h00;
				end else if (st.trigB[1] && !st.trigB[2]) begin
					trigStep = 2'h2;
				end
			end
			if (trigStep != 2'h0) begin
				step = 1'b1;
				next_st.patIdx = pvt_wrap(st.patIdx, {6'h0, trigStep}, st.patCount);
			end
		end
		// Microsecond tick from the one reference clock
		next_st.usCnt = (st.usCnt == 7'(US_CYCLES - 1)) ? 7'h0 : st.usCnt + 7'h1;
		// Exposure timer
		case (st.expo)
			PVT_IDLE: begin
				if (step) begin
					next_st.expo = PVT_EXPOSE;
				end
			end
			PVT_EXPOSE: begin
				if (st.usCnt == 7'(US_CYCLES - 1)) begin
					next_st.expoCnt = st.expoCnt + 16'h1;
					if (st.expoCnt + 16'h1 >= st.expoUs) begin
						next_st.expo = PVT_IDLE;
					end
				end
			end
			default: next_st.expo = PVT_IDLE;
		endcase
		if (step) begin
			next_st.expo = PVT_EXPOSE;
			next_st.expoCnt = 16'h0;
		end
		next_st.expoStrobe = (next_st.expo == PVT_EXPOSE);
		next_st.firstStrobe = next_st.expoStrobe && next_st.patIdx == 8'h00;
	end

	// State register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st <= '0;
			st.ctrl <= CTRL_RESET;
			st.patCount <= PATTERN_RESET;
			st.expoUs <= EXPOSURE_RESET;
			st.addr <= ADDR_LOW_SET;
		end else begin
			st <= next_st;
		end
	end

	// Outputs straight from state
	assign awready = st.awready;
	assign wready = st.wready;
	assign bresp = st.bresp;
	assign bvalid = st.bvalid;
	assign arready = st.arready;
	assign rdata = st.rdata;
	assign rresp = st.rresp;
	assign rvalid = st.rvalid;
	assign exposureStrobeOut = st.expoStrobe;
	assign firstPatternStrobeOut = st.firstStrobe;
	assign addrSelOut = st.gpioOut;
	assign addrSelOe = st.addrSelOe;
	assign hostCtrlAddress = st.addr;
	assign pixOut = st.pixOut;
	assign pixOutValid = st.pixOutValid;
	assign frameStartOut = st.frameStart;
	assign frameRepeatOut = st.frameRepeat;
	assign patternIndexOut = st.patIdx;

	// Checks
	a_frame_start: assert property (@(posedge clk) disable iff (rst)
		vsRise |=> frameStartOut) else $error("frame sync not adopted");
	a_repeat_flag: assert property (@(posedge clk) disable iff (rst)
		vsRise && !st.dataSeen |=> frameRepeatOut && $stable(st.frameCount))
		else $error("empty frame not repeated");
	a_no_lost_push: assert property (@(posedge clk) disable iff (rst)
		st.syncLost && !vsRise |=> !st.pushValid) else $error("pixel taken without sync");
	a_pattern_bits: assert property (@(posedge clk) disable iff (rst)
		st.pushValid && $past(st.ctrl[CTRL_PAT]) |-> st.pushData[29:24] == 6'h00)
		else $error("pattern word wider than 24 bits");
	a_expo_start: assert property (@(posedge clk) disable iff (rst)
		step |=> exposureStrobeOut [*2]) else $error("exposure not started");
	a_first_mark: assert property (@(posedge clk) disable iff (rst)
		exposureStrobeOut && patternIndexOut == 8'h00 |-> firstPatternStrobeOut)
		else $error("first pattern not marked");
	a_strap_addr: assert property (@(posedge clk) disable iff (rst)
		$rose(st.initDone) |-> hostCtrlAddress == ($past(st.strap[1]) ? 7'h3a : 7'h34))
		else $error("wrong slave address");
	a_gpio_gate: assert property (@(posedge clk) disable iff (rst)
		!st.initDone |=> !addrSelOe) else $error("strap pin driven during init");
	a_alternate: assert property (@(posedge clk) disable iff (rst)
		st.ctrl[CTRL_PAT] && st.ctrl[CTRL_TRIG] && st.trigA[1] && !st.trigA[2]
		|=> patternIndexOut <= 8'h01) else $error("alternate left the pair");
	a_pause_hold: assert property (@(posedge clk) disable iff (rst)
		st.ctrl[CTRL_PAT] && !st.ctrl[CTRL_TRIG] && st.paused ##1 $stable(st.ctrl)
		|-> $stable(patternIndexOut)) else $error("pattern moved while paused");
endmodule

// [dv/pvt_pixel_source.sv]
// Purpose: pixel source model for the parallel and serial ports
// Assumes: pixel clock is clk/8, words launched while it is low
// Notes: data lines invert their previous value on each idle beat
`timescale 1ns/1ns
module pvt_pixel_source (
	// Clock
	input wire logic clk,
	// Parallel port pins
	output logic pixClk,
	output logic frameSync,
	output logic lineSync,
	output logic pixValid,
	output logic [29:0] pixData,
	// Serial port after the receivers, lanes A B C E
	output logic lvdsClk,
	output logic [3:0] lvdsLanes
);
	// Idle pins at time zero
	initial begin
		pixClk = 0;
		frameSync = 0;
		lineSync = 0;
		pixValid = 0;
		pixData = '0;
		lvdsClk = 0;
		lvdsLanes = '0;
	end
	// One pixel period, launched at the clock fall
	task automatic beat(input logic v, input logic fs, input logic [29:0] d);
		@(posedge clk);
		pixClk <= 0;
		frameSync <= fs;
		lineSync <= v;
		pixValid <= v;
		pixData <= v ? d : ~pixData;
		repeat (4) @(posedge clk);
		pixClk <= 1;
		repeat (3) @(posedge clk);
	endtask
	// Two sync beats, then n words in one frame
	task automatic frame(input int n, input logic [29:0] base);
		for (int i = 0; i < n + 3; i++) begin
			beat(i >= 2 && i < n + 2, i < 2, base ^ 30'(i - 2));
		end
	endtask
	// Frame sync, line sync rise to align, then eight nibbles, first on top
	task automatic serial(input logic [31:0] w);
		beat(0, 1, '0);
		beat(1, 0, '0);
		for (int k = 7; k >= 0; k--) begin
			@(posedge clk);
			lvdsClk <= 0;
			lvdsLanes <= w[4*k+:4];
			repeat (4) @(posedge clk);
			lvdsClk <= 1;
			repeat (3) @(posedge clk);
		end
	endtask
endmodule

// [dv/tb_top.sv]
// Purpose: register, pixel and trigger tests of the front end
// Assumes: AXI4-Lite master tasks, pixel source model
// Notes: sync timeout shortened to 200 cycles
`timescale 1ns/1ns
module tb_top import pvt_pkg::*;;
	// Bus, pixel port, triggers and strap
	logic clk = 0, rst = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [7:0] awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0, rdata;
	logic [3:0] wstrb = 4'hf;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [29:0] rgbPixelBus, pixOut;
	logic sourcePixelClock, frameSyncIn, lineSyncIn, pixelValidIn, lvdsClockIn;
	logic [3:0] lanes;
	logic advanceTriggerIn = 0, pauseTriggerIn = 0, strap = 1, pixOutReady = 1;
	logic exposureStrobeOut, firstPatternStrobeOut, addrSelOut, addrSelOe;
	logic pixOutValid, frameStartOut, frameRepeatOut, lastRepeat = 0;
	logic [6:0] hostCtrlAddress;
	logic [7:0] patternIndexOut;
	wire logic addrSelIn;
	logic [29:0] q[$];
	int n_mismatch = 0, checks_done = 0;
	int trigExp[9] = '{1, 2, 3, 0, 0, 1, 0, 2, 0};
	logic [11:0] ctrlSet[4] = '{12'h900, 12'h901, 12'h480, 12'h481};

	// Pin level from strap and design drive
	assign addrSelIn = addrSelOe ? addrSelOut : strap;
	always #5 clk = ~clk;

	pvt_pixel_source pvt_pixel_source_i (.clk, .pixClk(sourcePixelClock),
		.frameSync(frameSyncIn), .lineSync(lineSyncIn), .pixValid(pixelValidIn),
		.pixData(rgbPixelBus), .lvdsClk(lvdsClockIn), .lvdsLanes(lanes));
	pvt_input_trigger #(.SYNC_TIMEOUT(200), .FIFO_DEPTH(8)) pvt_input_trigger_i (
		.clk, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
		.bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
		.rgbPixelBus, .sourcePixelClock, .frameSyncIn, .lineSyncIn, .pixelValidIn,
		.lvdsClockIn, .lvdsLaneA(lanes[3]), .lvdsLaneB(lanes[2]), .lvdsLaneC(lanes[1]),
		.lvdsLaneE(lanes[0]), .advanceTriggerIn, .pauseTriggerIn, .exposureStrobeOut,
		.firstPatternStrobeOut, .addrSelIn, .addrSelOut, .addrSelOe, .hostCtrlAddress,
		.pixOut, .pixOutValid, .pixOutReady, .frameStartOut, .frameRepeatOut, .patternIndexOut);

	// Capture stream words and the repeat flag
	always @(posedge clk) begin
		if (pixOutValid === 1 && pixOutReady) begin
			q.push_back(pixOut);
		end
		if (frameStartOut === 1) begin
			lastRepeat <= frameRepeatOut;
		end
	end

	task automatic stop_test;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		checks_done++;
		if (s !== e) begin
			$display("[ERR] %s expected %h seen %h", nm, e, s);
			n_mismatch++;
		end
	endtask
	// Write: address and data released as each is taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic awDone, wDone;
		awDone = 0;
		wDone = 0;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		while (!(awDone && wDone)) begin
			@(posedge clk);
			if (awready === 1) begin
				awDone = 1;
				awvalid <= 0;
			end
			if (wready === 1) begin
				wDone = 1;
				wvalid <= 0;
			end
		end
		while (bvalid !== 1) @(posedge clk);
		chk("bresp", er, bresp);
		bready <= 0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		while (arready !== 1) @(posedge clk);
		arvalid <= 0;
		while (rvalid !== 1) @(posedge clk);
		d = rdata;
		chk("rresp", er, rresp);
		rready <= 0;
	endtask
	task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		rd(a, d, RESP_OKAY);
		chk(nm, e, d);
	endtask
	// Expected word from lane selects and mode
	function automatic logic [9:0] lane(input logic [1:0] s, input logic [29:0] d);
		return s == 0 ? d[29:20] : s == 1 ? d[19:10] : d[9:0];
	endfunction
	function automatic logic [29:0] pixExp(input logic [11:0] c, input logic [29:0] d);
		logic [9:0] r, g, b;
		r = lane(c[SWAP_R+:2], d);
		g = lane(c[SWAP_G+:2], d);
		b = lane(c[SWAP_B+:2], d);
		return c[CTRL_PAT] ? {6'h0, r[9:2], g[9:2], b[9:2]} : {r, g, b};
	endfunction
	task automatic frameChk(input logic [11:0] c);
		logic [29:0] base;
		base = {18'h2a5, c};
		wr(REG_CTRL, {20'h0, c}, RESP_OKAY);
		q.delete();
		pvt_pixel_source_i.frame(4, base);
		repeat (10) @(posedge clk);
		chk("count", 4, q.size());
		for (int k = 0; k < 4; k++) chk("pixel", pixExp(c, base ^ 30'(k)), q[k]);
	endtask
	// One serial word; width code 0 keeps 8, 1 keeps 9, else 10 bits per lane
	task automatic serChk(input logic [11:0] c, input logic [31:0] w);
		logic [9:0] m;
		m = c[CTRL_WIDTH+:2] == 2'h0 ? 10'h3fc : c[CTRL_WIDTH+:2] == 2'h1 ? 10'h3fe : 10'h3ff;
		wr(REG_CTRL, {20'h0, c}, RESP_OKAY);
		q.delete();
		pvt_pixel_source_i.serial(w);
		repeat (10) @(posedge clk);
		chk("serial count", 1, q.size());
		chk("serial word", pixExp(c, w[29:0] & {3{m}}), q[0]);
	endtask

	// Main sequence
	initial begin
		logic [31:0] d;
		repeat (12) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		chk("address", ADDR_LOW_SET, hostCtrlAddress);
		chk("drive", 0, addrSelOe);
		rc("ctrl", REG_CTRL, CTRL_RESET);
		rc("pattern", REG_PATTERN, PATTERN_RESET);
		rc("exposure", REG_EXPOSURE, EXPOSURE_RESET);
		wstrb <= 4'h1;
		wr(REG_EXPOSURE, 32'hffffff77, RESP_OKAY);
		wstrb <= 4'hf;
		rc("strobe", REG_EXPOSURE, 32'h377);
		serChk(12'h902, 32'h9abcdef1);
		serChk(12'h912, 32'h2468ace1);
		serChk(12'h923, 32'h3579bdf0);
		wr(8'h40, 32'h1, RESP_SLVERR);
		rd(8'h40, d, RESP_SLVERR);
		chk("unmapped", 0, d);
		foreach (ctrlSet[i]) frameChk(ctrlSet[i]);
		pvt_pixel_source_i.frame(0, '0);
		chk("repeat", 0, lastRepeat);
		pvt_pixel_source_i.frame(0, '0);
		chk("repeat", 1, lastRepeat);
		rc("frames", REG_FRAMES, 32'h00020007);
		repeat (250) @(posedge clk);
		rd(REG_STATUS, d, RESP_OKAY);
		chk("sync lost", 1, d[ST_LOST]);
		// Fill the buffer while the far side stalls
		pixOutReady <= 0;
		q.delete();
		pvt_pixel_source_i.frame(12, 30'h1234567);
		rd(REG_STATUS, d, RESP_OKAY);
		chk("overflow", 1, d[ST_OVF]);
		pixOutReady <= 1;
		repeat (20) @(posedge clk);
		chk("kept", 1, q.size() >= 8 && q.size() < 12);
		chk("oldest", pixExp(12'h481, 30'h1234567), q[0]);
		wr(REG_STATUS, 32'h2, RESP_OKAY);
		rd(REG_STATUS, d, RESP_OKAY);
		chk("overflow", 0, d[ST_OVF]);
		// Pattern steps, pause and strobes
		wr(REG_PATTERN, 32'h4, RESP_OKAY);
		wr(REG_EXPOSURE, 32'h2, RESP_OKAY);
		wr(REG_CTRL, 32'h901, RESP_OKAY);
		for (int i = 0; i < 9; i++) begin
			if (i == 5) wr(REG_CTRL, 32'h905, RESP_OKAY);
			@(posedge clk);
			pauseTriggerIn <= (i == 4);
			repeat (4) @(posedge clk);
			if (i >= 7) pauseTriggerIn <= 1;
			else advanceTriggerIn <= 1;
			repeat (4) @(posedge clk);
			advanceTriggerIn <= 0;
			pauseTriggerIn <= 0;
			repeat (20) @(posedge clk);
			chk("index", trigExp[i], patternIndexOut);
			chk("expose", i != 4, exposureStrobeOut);
			chk("first", i != 4 && trigExp[i] == 0, firstPatternStrobeOut);
			repeat (200) @(posedge clk);
			chk("expose end", 0, exposureStrobeOut);
		end
		// Strap read once, pin then general purpose
		strap <= 0;
		repeat (2) @(posedge clk);
		chk("address", ADDR_HIGH_SET, hostCtrlAddress);
		rd(REG_STATUS, d, RESP_OKAY);
		chk("init", 1, d[ST_INIT]);
		chk("status address", ADDR_HIGH_SET, d[22:16]);
		wr(REG_GPIO, 32'h3, RESP_OKAY);
		@(posedge clk);
		chk("drive", 1, addrSelOe);
		rc("gpio", REG_GPIO, 32'h7);
		stop_test;
	end

	// Watchdog against hangs
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		stop_test;
	end
endmodule
